// [ccr_pkg.sv]
// constants and types shared by the configuration cycle router
package ccr_pkg;
    // I/O addresses of the two host-visible words
    localparam logic [15:0] CCR_SEL_ADDR   = 16'h0cf8;
    localparam logic [15:0] CCR_WIN_ADDR   = 16'h0cfc;
    // select latch layout
    localparam int          CCR_EN_BIT     = 31;
    localparam int          CCR_BUS_HI     = 23;
    localparam int          CCR_BUS_LO     = 16;
    localparam int          CCR_DEV_HI     = 15;
    localparam int          CCR_DEV_LO     = 11;
    localparam int          CCR_FN_HI      = 10;
    localparam int          CCR_FN_LO      = 8;
    localparam int          CCR_REG_HI     = 7;
    localparam int          CCR_REG_LO     = 2;
    localparam logic [31:0] CCR_SEL_RST    = 32'h0000_0000;
    localparam logic [31:0] CCR_SEL_WMASK  = 32'h80ff_fffc;
    // fixed internal device numbers on bus 0
    localparam logic [4:0]  CCR_DEV_HOST   = 5'h00;
    localparam logic [4:0]  CCR_DEV_WIDE0  = 5'h02;
    localparam int          CCR_N_WIDE     = 3;
    // answers and masks
    localparam logic [3:0]  CCR_BE_DWORD   = 4'hf;
    localparam logic [31:0] CCR_ALL_ONES   = 32'hffff_ffff;
    localparam logic [7:0]  CCR_BUS_ZERO   = 8'h00;
    // which link a forwarded cycle leaves on
    typedef enum logic [1:0] {
        CCR_LNK_PRI,
        CCR_LNK_B,
        CCR_LNK_C,
        CCR_LNK_D
    } ccr_link_e;
    // kind of forwarded cycle
    typedef enum logic [1:0] {
        CCR_CYC_IO,
        CCR_CYC_CFG0,
        CCR_CYC_CFG1
    } ccr_cyc_e;
endpackage

// [ccr_router.sv]
// configuration cycle router: select latch, window decode and link routing
`timescale 1ns/1ps
module ccr_router
    import ccr_pkg::*;
(
    // clock and reset
    input  wire logic        i_ref_clk,
    input  wire logic        i_rst_n,
    // host I/O cycles
    input  wire logic        i_io_req,
    input  wire logic        i_io_wr,
    input  wire logic [15:0] i_io_addr,
    input  wire logic [3:0]  i_io_be,
    input  wire logic [31:0] i_io_wdata,
    output logic             o_io_ack,
    output logic             o_io_mabort,
    output logic [31:0]      o_io_rdata,
    // wide bridge state
    input  wire logic [2:0]  i_wide_en,
    input  wire logic [7:0]  i_sec_bus [CCR_N_WIDE],
    input  wire logic [7:0]  i_sub_bus [CCR_N_WIDE],
    // cycles forwarded on the hub links
    output logic             o_dn_req,
    output ccr_link_e        o_dn_link,
    output ccr_cyc_e         o_dn_kind,
    output logic             o_dn_wr,
    output logic [31:0]      o_dn_addr,
    output logic [3:0]       o_dn_be,
    output logic [31:0]      o_dn_wdata,
    input  wire logic        i_dn_ack,
    input  wire logic        i_dn_mabort,
    input  wire logic [31:0] i_dn_rdata,
    // accesses serviced by internal devices
    output logic             o_loc_req,
    output logic [1:0]       o_loc_dev,
    output logic [2:0]       o_loc_fn,
    output logic [5:0]       o_loc_reg,
    output logic             o_loc_wr,
    output logic [3:0]       o_loc_be,
    output logic [31:0]      o_loc_wdata,
    input  wire logic        i_loc_ack,
    input  wire logic [31:0] i_loc_rdata
);

    typedef enum logic [1:0] {ST_IDLE, ST_LOCAL, ST_DOWN} ccr_state_e;
    typedef enum logic [1:0] {ACT_SEL, ACT_LOC, ACT_ABORT, ACT_FWD} ccr_act_e;

    ccr_state_e  state_reg;
    logic [31:0] sel_reg;
    ccr_act_e    act_next;
    ccr_link_e   link_next;
    ccr_cyc_e    kind_next;
    logic [1:0]  locdev_next;
    logic [2:0]  wide_hit;
    logic        hit_sel;
    logic        hit_win;
    logic        dword;
    logic        start;
    logic [7:0]  bus;
    logic [4:0]  dev;
    logic [31:0] cfg_addr;

    // field views of the select latch
    assign bus      = sel_reg[CCR_BUS_HI:CCR_BUS_LO];
    assign dev      = sel_reg[CCR_DEV_HI:CCR_DEV_LO];
    assign cfg_addr = {8'h00, sel_reg[CCR_BUS_HI:CCR_REG_LO], 2'b00};
    assign hit_sel  = i_io_addr[15:2] == CCR_SEL_ADDR[15:2];
    assign hit_win  = i_io_addr[15:2] == CCR_WIN_ADDR[15:2];
    assign dword    = i_io_be == CCR_BE_DWORD;
    assign start    = (state_reg == ST_IDLE) && i_io_req;

    // bridge range compare, one per wide link
    genvar gi;
    generate
        for (gi = 0; gi < CCR_N_WIDE; gi++) begin : g_range
            assign wide_hit[gi] = i_wide_en[gi] && (bus != CCR_BUS_ZERO)
                                  && (bus > i_sec_bus[gi]) && (bus <= i_sub_bus[gi]);
        end
    endgenerate

    // decode of one host cycle; the lowest link wins if ranges overlap
    always_comb begin
        act_next    = ACT_FWD;
        link_next   = CCR_LNK_PRI;
        kind_next   = CCR_CYC_IO;
        locdev_next = 2'd0;
        if (hit_sel && dword) begin
            act_next = ACT_SEL;
        end else if (hit_win && sel_reg[CCR_EN_BIT]) begin
            kind_next = CCR_CYC_CFG1;
            if (bus == CCR_BUS_ZERO) begin
                kind_next = CCR_CYC_CFG0;
                if (dev == CCR_DEV_HOST) begin
                    act_next = ACT_LOC;
                end else if (dev >= CCR_DEV_WIDE0 && dev < CCR_DEV_WIDE0 + 5'(CCR_N_WIDE)) begin
                    locdev_next = 2'(dev - CCR_DEV_WIDE0 + 5'd1);
                    act_next    = i_wide_en[2'(dev - CCR_DEV_WIDE0)] ? ACT_LOC : ACT_ABORT;
                end
            end else if (wide_hit[0]) begin
                link_next = CCR_LNK_B;
            end else if (wide_hit[1]) begin
                link_next = CCR_LNK_C;
            end else if (wide_hit[2]) begin
                link_next = CCR_LNK_D;
            end
            // anything unclaimed stays on the primary link, as Type 1, or as Type 0 on bus 0
        end
        // partial latch access, disabled window and foreign I/O pass as I/O
    end

    // select latch; reserved bits are forced so a blind write is safe
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            sel_reg <= CCR_SEL_RST;
        end else if (start && act_next == ACT_SEL && i_io_wr) begin
            sel_reg <= i_io_wdata & CCR_SEL_WMASK;
        end
    end

    // sequencer: one host cycle in flight at a time
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            state_reg <= ST_IDLE;
        end else begin
            unique case (state_reg)
                ST_IDLE: begin
                    if (i_io_req && act_next == ACT_LOC) begin
                        state_reg <= ST_LOCAL;
                    end else if (i_io_req && act_next == ACT_FWD) begin
                        state_reg <= ST_DOWN;
                    end
                end
                ST_LOCAL: begin
                    if (i_loc_ack) begin
                        state_reg <= ST_IDLE;
                    end
                end
                ST_DOWN: begin
                    if (i_dn_ack) begin
                        state_reg <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // forwarded cycle, held until the link acknowledges
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            o_dn_req   <= 1'b0;
            o_dn_link  <= CCR_LNK_PRI;
            o_dn_kind  <= CCR_CYC_IO;
            o_dn_wr    <= 1'b0;
            o_dn_addr  <= 32'h0000_0000;
            o_dn_be    <= 4'h0;
            o_dn_wdata <= 32'h0000_0000;
        end else if (start && act_next == ACT_FWD) begin
            o_dn_req   <= 1'b1;
            o_dn_link  <= link_next;
            o_dn_kind  <= kind_next;
            o_dn_wr    <= i_io_wr;
            o_dn_addr  <= (kind_next == CCR_CYC_IO) ? {16'h0000, i_io_addr} : cfg_addr;
            o_dn_be    <= i_io_be;
            o_dn_wdata <= i_io_wdata;
        end else if (i_dn_ack) begin
            o_dn_req <= 1'b0;
        end
    end

    // internal device access, held until that device answers
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            o_loc_req   <= 1'b0;
            o_loc_dev   <= 2'd0;
            o_loc_fn    <= 3'd0;
            o_loc_reg   <= 6'd0;
            o_loc_wr    <= 1'b0;
            o_loc_be    <= 4'h0;
            o_loc_wdata <= 32'h0000_0000;
        end else if (start && act_next == ACT_LOC) begin
            o_loc_req   <= 1'b1;
            o_loc_dev   <= locdev_next;
            o_loc_fn    <= sel_reg[CCR_FN_HI:CCR_FN_LO];
            o_loc_reg   <= sel_reg[CCR_REG_HI:CCR_REG_LO];
            o_loc_wr    <= i_io_wr;
            o_loc_be    <= i_io_be;
            o_loc_wdata <= i_io_wdata;
        end else if (i_loc_ack) begin
            o_loc_req <= 1'b0;
        end
    end

    // answer to the host, a one-cycle pulse
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            o_io_ack    <= 1'b0;
            o_io_mabort <= 1'b0;
            o_io_rdata  <= 32'h0000_0000;
        end else begin
            o_io_ack    <= 1'b0;
            o_io_mabort <= 1'b0;
            if (start && act_next == ACT_SEL) begin
                o_io_ack   <= 1'b1;
                o_io_rdata <= sel_reg;
            end else if (start && act_next == ACT_ABORT) begin
                o_io_ack    <= 1'b1;
                o_io_mabort <= i_io_wr;
                o_io_rdata  <= CCR_ALL_ONES;
            end else if (state_reg == ST_LOCAL && i_loc_ack) begin
                o_io_ack   <= 1'b1;
                o_io_rdata <= i_loc_rdata;
            end else if (state_reg == ST_DOWN && i_dn_ack) begin
                o_io_ack    <= 1'b1;
                o_io_mabort <= i_dn_mabort;
                o_io_rdata  <= i_dn_rdata;
            end
        end
    end

    // checks on the routing decisions
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);

    AST_SEL_RSVD_ZERO: assert property (
        sel_reg[30:24] == 7'h00 && sel_reg[1:0] == 2'b00)
        else $error("select latch reserved bits not zero");

    AST_SEL_PARTIAL_KEEP: assert property (
        start && hit_sel && !dword |=> $stable(sel_reg) ##0 o_dn_req && o_dn_kind == CCR_CYC_IO)
        else $error("partial latch access not forwarded as I/O");

    AST_SEL_WRITE_TAKES: assert property (
        start && hit_sel && dword && i_io_wr |=> sel_reg == ($past(i_io_wdata) & CCR_SEL_WMASK) && o_io_ack)
        else $error("doubleword latch write not stored");

    AST_WIN_OFF_IO: assert property (
        start && hit_win && !sel_reg[CCR_EN_BIT]
        |=> o_dn_req && o_dn_kind == CCR_CYC_IO && o_dn_link == CCR_LNK_PRI && !o_loc_req)
        else $error("disabled window access not plain I/O");

    AST_BUS0_TYPE0: assert property (
        o_dn_req && o_dn_kind == CCR_CYC_CFG0
        |-> o_dn_link == CCR_LNK_PRI && o_dn_addr[23:16] == 8'h00 && o_dn_addr[15:11] != CCR_DEV_HOST)
        else $error("type 0 cycle misrouted");

    AST_HOST_LOCAL: assert property (
        start && hit_win && sel_reg[CCR_EN_BIT] && bus == CCR_BUS_ZERO && dev == CCR_DEV_HOST
        |=> o_loc_req && o_loc_dev == 2'd0 && !o_dn_req)
        else $error("host device access left the block");

    AST_REG_FIELD: assert property (
        o_dn_req && o_dn_kind != CCR_CYC_IO |-> o_dn_addr[7:2] == sel_reg[CCR_REG_HI:CCR_REG_LO])
        else $error("register field not on address bits 7:2");

    AST_WIDE_RANGE: assert property (
        o_dn_req && o_dn_link != CCR_LNK_PRI |-> o_dn_kind == CCR_CYC_CFG1
        && o_dn_addr[23:16] > i_sec_bus[2'(o_dn_link) - 2'd1]
        && o_dn_addr[23:16] <= i_sub_bus[2'(o_dn_link) - 2'd1])
        else $error("wide link cycle outside bridge range");

    AST_PRI_TYPE1: assert property (
        start && act_next == ACT_FWD && kind_next == CCR_CYC_CFG1 && wide_hit == 3'b000
        |=> o_dn_link == CCR_LNK_PRI && o_dn_kind == CCR_CYC_CFG1)
        else $error("unclaimed bus not sent type 1 on primary");

    AST_ABORT_ANSWER: assert property (
        start && act_next == ACT_ABORT
        |=> o_io_ack && o_io_rdata == CCR_ALL_ONES && o_io_mabort == $past(i_io_wr) ##1 !o_io_ack)
        else $error("disabled bridge answer wrong");

    AST_DN_ANSWER: assert property (
        state_reg == ST_DOWN && i_dn_ack |=> o_io_ack && !o_dn_req)
        else $error("link answer not returned to host");

    AST_LOC_ANSWER: assert property (
        state_reg == ST_LOCAL && i_loc_ack |=> o_io_ack && !o_loc_req)
        else $error("local answer not returned to host");

    // handshake holding: the far side sees steady fields until it answers
    AST_DN_HOLD: assert property (
        o_dn_req && !i_dn_ack
        |=> o_dn_req && $stable(o_dn_addr) && $stable(o_dn_link) && $stable(o_dn_kind))
        else $error("forwarded cycle changed before its answer");

    AST_LOC_HOLD: assert property (
        o_loc_req && !i_loc_ack
        |=> o_loc_req && $stable(o_loc_dev) && $stable(o_loc_fn) && $stable(o_loc_reg))
        else $error("local access changed before its answer");

    AST_ONE_TARGET: assert property (
        !(o_loc_req && o_dn_req))
        else $error("cycle sent both locally and to a link");

    AST_IDLE_QUIET: assert property (
        state_reg == ST_IDLE |-> !o_dn_req && !o_loc_req)
        else $error("request left standing while idle");

    // routing checks on the forwarded cycle and the local access
    AST_TYPE1_BUS: assert property (
        o_dn_req && o_dn_kind == CCR_CYC_CFG1 |-> o_dn_addr[23:16] != CCR_BUS_ZERO)
        else $error("type 1 cycle carries bus zero");

    AST_CFG_ADDR: assert property (
        o_dn_req && o_dn_kind != CCR_CYC_IO
        |-> o_dn_addr[31:24] == 8'h00 && o_dn_addr[1:0] == 2'b00
            && o_dn_addr[CCR_BUS_HI:CCR_REG_LO] == sel_reg[CCR_BUS_HI:CCR_REG_LO])
        else $error("configuration address does not follow the latch");

    AST_IO_PRIMARY: assert property (
        o_dn_req && o_dn_kind == CCR_CYC_IO
        |-> o_dn_link == CCR_LNK_PRI && o_dn_addr[31:16] == 16'h0000)
        else $error("plain I/O cycle not on the primary link");

    AST_WIDE_ENABLED: assert property (
        o_dn_req && o_dn_link != CCR_LNK_PRI |-> i_wide_en[2'(o_dn_link) - 2'd1])
        else $error("cycle sent on a disabled wide link");

    AST_LOC_ENABLED: assert property (
        o_loc_req && o_loc_dev != 2'd0 |-> i_wide_en[o_loc_dev - 2'd1])
        else $error("disabled bridge serviced locally");

    AST_BUS0_LOCAL: assert property (
        o_loc_req |-> sel_reg[CCR_BUS_HI:CCR_BUS_LO] == CCR_BUS_ZERO
            && o_loc_fn == sel_reg[CCR_FN_HI:CCR_FN_LO] && o_loc_reg == sel_reg[CCR_REG_HI:CCR_REG_LO])
        else $error("local access not for a bus zero device");

    // answers to the host
    AST_WIN_ENABLED: assert property (
        start && hit_win && sel_reg[CCR_EN_BIT]
        |=> o_loc_req || o_io_ack || (o_dn_req && o_dn_kind != CCR_CYC_IO))
        else $error("enabled window access not made a configuration cycle");

    AST_SEL_READ: assert property (
        start && hit_sel && dword && !i_io_wr |=> o_io_ack && o_io_rdata == $past(sel_reg))
        else $error("latch read did not return the latch");

    AST_ABORT_QUIET: assert property (
        start && act_next == ACT_ABORT |=> !o_dn_req && !o_loc_req)
        else $error("disabled bridge access left the block");

    AST_MABORT_ACK: assert property (
        o_io_mabort |-> o_io_ack)
        else $error("master abort without an answer");

    // main scenarios reached
    COV_LATCH_WRITE: cover property (start && act_next == ACT_SEL && i_io_wr);
    COV_WIDE_ROUTE:  cover property (o_dn_req && o_dn_link == CCR_LNK_D);
    COV_LOCAL_DONE:  cover property (o_loc_req ##[1:8] o_io_ack);
    COV_ABORT:       cover property (o_io_mabort);
    COV_TYPE0:       cover property (o_dn_req && o_dn_kind == CCR_CYC_CFG0);

endmodule

// [ccr_far_model.sv]
// far-side model answering hub link and internal device requests
`timescale 1ns/1ps
module ccr_far_model (
    // clock
    input  wire logic        i_ref_clk,
    // requests from the router
    input  wire logic        i_dn_req,
    input  wire logic [31:0] i_dn_addr,
    input  wire logic        i_loc_req,
    input  wire logic [10:0] i_loc_id,
    // answers
    output logic             o_dn_ack,
    output logic             o_dn_mabort,
    output logic [31:0]      o_dn_rdata,
    output logic             o_loc_ack,
    output logic [31:0]      o_loc_rdata
);
    int   dn_cnt;
    int   loc_cnt;
    logic dn_fire;
    logic loc_fire;
    initial begin
        {o_dn_ack, o_dn_mabort, o_loc_ack} = 3'h0;
        dn_cnt = 0;
        loc_cnt = 0;
    end
    // random stall before each answer; data is scrambled outside ack cycles
    // a link cycle with address bit 2 set is answered with a master abort
    always @(negedge i_ref_clk) begin
        dn_fire = 1'b0;
        loc_fire = 1'b0;
        if (i_dn_req === 1'b1) begin
            if (dn_cnt == 0) dn_cnt = 1 + $urandom_range(0, 4);
            dn_cnt = dn_cnt - 1;
            dn_fire = (dn_cnt == 0);
        end
        if (i_loc_req === 1'b1) begin
            if (loc_cnt == 0) loc_cnt = 1 + $urandom_range(0, 4);
            loc_cnt = loc_cnt - 1;
            loc_fire = (loc_cnt == 0);
        end
        o_dn_ack <= dn_fire;
        o_dn_mabort <= dn_fire & i_dn_addr[2];
        o_dn_rdata <= dn_fire ? ~i_dn_addr : $urandom;
        o_loc_ack <= loc_fire;
        o_loc_rdata <= loc_fire ? {21'h0, i_loc_id} : $urandom;
    end
endmodule

// [tb.sv]
// self-checking bench for the configuration cycle router
`timescale 1ns/1ps
module tb;
    import ccr_pkg::*;
    logic        i_ref_clk, i_rst_n, io_req, io_wr, io_ack, io_mab, dn_req, dn_wr, dn_ack, dn_mab;
    logic        loc_req, loc_wr, loc_ack;
    logic [15:0] io_addr;
    logic [3:0]  io_be, dn_be, loc_be;
    logic [31:0] io_wdata, io_rdata, dn_addr, dn_wdata, dn_rdata, loc_wdata, loc_rdata, sel;
    logic [2:0]  wide_en, loc_fn;
    logic [1:0]  loc_dev;
    logic [5:0]  loc_reg;
    logic [7:0]  sec [CCR_N_WIDE];
    logic [7:0]  sub [CCR_N_WIDE];
    ccr_link_e   dn_link;
    ccr_cyc_e    dn_kind;
    int          n_fail = 0;
    int          num_checks = 0;

    ccr_router dut (
        .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_io_req(io_req), .i_io_wr(io_wr),
        .i_io_addr(io_addr), .i_io_be(io_be), .i_io_wdata(io_wdata), .o_io_ack(io_ack),
        .o_io_mabort(io_mab), .o_io_rdata(io_rdata), .i_wide_en(wide_en), .i_sec_bus(sec),
        .i_sub_bus(sub), .o_dn_req(dn_req), .o_dn_link(dn_link), .o_dn_kind(dn_kind),
        .o_dn_wr(dn_wr), .o_dn_addr(dn_addr), .o_dn_be(dn_be), .o_dn_wdata(dn_wdata),
        .i_dn_ack(dn_ack), .i_dn_mabort(dn_mab), .i_dn_rdata(dn_rdata), .o_loc_req(loc_req),
        .o_loc_dev(loc_dev), .o_loc_fn(loc_fn), .o_loc_reg(loc_reg), .o_loc_wr(loc_wr),
        .o_loc_be(loc_be), .o_loc_wdata(loc_wdata), .i_loc_ack(loc_ack), .i_loc_rdata(loc_rdata)
    );
    ccr_far_model far (
        .i_ref_clk(i_ref_clk), .i_dn_req(dn_req), .i_dn_addr(dn_addr), .i_loc_req(loc_req),
        .i_loc_id({loc_dev, loc_fn, loc_reg}), .o_dn_ack(dn_ack), .o_dn_mabort(dn_mab),
        .o_dn_rdata(dn_rdata), .o_loc_ack(loc_ack), .o_loc_rdata(loc_rdata)
    );

    // free-running 125 MHz clock
    initial begin
        i_ref_clk = 1'b0;
        forever #4 i_ref_clk = ~i_ref_clk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic give_verdict();
        if (n_fail == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // one host cycle, with the reference decode worked out beforehand
    task automatic io(input logic w, input logic [15:0] a, input logic [3:0] be, input logic [31:0] d);
        int          dest, lnk, knd, dv;
        logic [31:0] ea, er;
        logic [1:0]  ld;
        logic        ab, sdn, slc;
        dv = int'(sel[15:11]);
        {dest, lnk, knd, ab, sdn, slc} = {32'd1, 32'd0, 32'd0, 3'h0};
        ea = {16'h0, a};
        er = ~ea;
        ld = 2'(dv == 0 ? 0 : dv - 1);
        if (a == CCR_SEL_ADDR && be == 4'hf) begin
            dest = 0;
            er = sel;
        end else if (a[15:2] == 14'h033f && sel[31]) begin
            knd = 1;
            ea = {8'h0, sel[23:2], 2'b00};
            er = ~ea;
            if (sel[23:16] != 8'h00) begin
                knd = 2;
                // scan downwards so the lowest matching bridge wins
                for (int i = 2; i >= 0; i--)
                    if (wide_en[i] && sel[23:16] > sec[i] && sel[23:16] <= sub[i]) lnk = i + 1;
            end else if (dv == 0 || (dv >= 2 && dv <= 4 && wide_en[dv-2])) begin
                dest = 2;
                er = {21'h0, ld, sel[10:2]};
            end else if (dv >= 2 && dv <= 4) begin
                dest = 0;
                er = CCR_ALL_ONES;
                ab = w;
            end
        end
        // the link model aborts forwarded cycles with address bit 2 set
        if (dest == 1) ab = ea[2];
        @(negedge i_ref_clk);
        {io_req, io_wr, io_addr, io_be, io_wdata} <= {1'b1, w, a, be, d};
        for (int k = 0; k < 20 && io_ack !== 1'b1; k++) begin
            @(posedge i_ref_clk);
            #1;
            if (dn_req === 1'b1 && !sdn) begin
                sdn = 1'b1;
                chk({dn_link, dn_kind, dn_wr, dn_be, 23'h0}, {2'(lnk), 2'(knd), w, be, 23'h0});
                chk(dn_addr, ea);
                if (w) chk(dn_wdata, d);
            end
            if (loc_req === 1'b1 && !slc) begin
                slc = 1'b1;
                chk({loc_wr, loc_be, loc_dev, loc_fn, loc_reg, 16'h0}, {w, be, ld, sel[10:2], 16'h0});
                if (w) chk(loc_wdata, d);
            end
        end
        chk({28'h0, io_ack, io_mab, sdn, slc}, {28'h0, 1'b1, ab, 1'(dest == 1), 1'(dest == 2)});
        if (!w) chk(io_rdata, er);
        if (w && be == 4'hf && a == CCR_SEL_ADDR) sel = d & CCR_SEL_WMASK;
        @(negedge i_ref_clk);
        io_req <= 1'b0;
    endtask

    // hang guard, far beyond the expected run length
    initial begin
        #400us;
        n_fail++;
        give_verdict();
    end

    initial begin
        void'($urandom(81886));
        {io_req, io_wr, io_addr, io_be, io_wdata} = '0;
        wide_en = 3'h7;
        sec = '{8'h01, 8'h07, 8'h0c};
        sub = '{8'h05, 8'h0c, 8'h0f};
        sel = CCR_SEL_RST;
        i_rst_n = 1'b0;
        repeat (5) @(negedge i_ref_clk);
        i_rst_n = 1'b1;
        io(0, CCR_SEL_ADDR, 4'hf, 32'h0);
        io(1, CCR_SEL_ADDR, 4'hf, 32'h7fff_ffff);
        io(0, CCR_SEL_ADDR, 4'hf, 32'h0);
        io(0, CCR_WIN_ADDR, 4'hf, 32'h0);
        io(1, CCR_SEL_ADDR, 4'h3, $urandom);
        // random latch contents, bridge enables and window accesses
        for (int i = 0; i < 150; i++) begin
            wide_en = 3'($urandom);
            io(1, CCR_SEL_ADDR, 4'hf, {1'($urandom_range(0, 5) != 0), 7'($urandom),
               8'($urandom_range(0, 1) ? 0 : $urandom_range(1, 16)),
               5'($urandom_range(0, 1) ? $urandom_range(0, 5) : $urandom), 11'($urandom)});
            io(0, CCR_SEL_ADDR, 4'hf, 32'h0);
            io(1'($urandom), $urandom_range(0, 7) ? 16'h0cfc | 16'($urandom_range(0, 3)) : 16'h0080,
               $urandom_range(0, 3) ? 4'hf : 4'($urandom), $urandom);
        end
        // reset in mid-run, between cycles, clears the latch again
        i_rst_n = 1'b0;
        repeat (2) @(negedge i_ref_clk);
        i_rst_n = 1'b1;
        sel = CCR_SEL_RST;
        io(0, CCR_SEL_ADDR, 4'hf, 32'h0);
        io(0, CCR_WIN_ADDR, 4'hf, 32'h0);
        give_verdict();
    end
endmodule
